/* File: dtc_defs.svh */
/*
  Constants of the dma transfer control block: register offsets, field
  positions, reset values and sizes.
  Assumes it is included by its bare name from the package and the modules.
*/
`ifndef DTC_DEFS_SVH
`define DTC_DEFS_SVH

// sizes
`define DTC_NCH          3
`define DTC_NFLAG        4
`define DTC_AW           20
`define DTC_BUF_W        28

// register byte offsets
`define DTC_RA_CTRL      8'h00
`define DTC_RA_STAT      8'h04
`define DTC_RO_CTL       4'h0
`define DTC_RO_SA        4'h4
`define DTC_RO_DA        4'h8

// global control fields
`define DTC_CTRL_DEFER   0

// channel control fields
`define DTC_CHCTL_W      6
`define DTC_CHCTL_EN     0
`define DTC_CHCTL_SINC   1
`define DTC_CHCTL_DINC   2
`define DTC_CHCTL_SEL    4

// status fields
`define DTC_STAT_BUSY    8
`define DTC_STAT_CH      9

// flag inputs
`define DTC_FLAG_SER0_TX 0
`define DTC_FLAG_SER0_RX 1

// reset values and masks
`define DTC_CHCTL_RST    6'h00
`define DTC_ADDR_RST     20'h00000
`define DTC_WORD_MASK    20'h0ffff

`endif

/* File: dtc_pkg.sv */
/*
  Types of the dma transfer control block.
  Assumes dtc_defs.svh is on the include path.
*/
`include "dtc_defs.svh"

package dtc_pkg;
  typedef enum logic [1:0] {
    DTC_IDLE = 2'b00,
    DTC_RD   = 2'b01,
    DTC_WR   = 2'b10
  } dtc_state_t;

  typedef logic [1:0]          dtc_ch_t;
  typedef logic [`DTC_AW-1:0]  dtc_addr_t;
endpackage

/* File: dtc_buf.sv */
/*
  Two-entry buffer with valid and ready on both sides.
  Assumes one clock and an asynchronous active-low reset; entries live in
  registers so the head word is a two-way select of them on rp_q.
*/
`timescale 1ns/1ns
`include "dtc_defs.svh"

module dtc_buf #(
  parameter int W = `DTC_BUF_W
) (
  input  wire logic         i_core_clk,
  input  wire logic         i_resetn,
  input  wire logic         i_in_valid,
  output logic              o_in_ready,
  input  wire logic [W-1:0] i_in_data,
  output logic              o_out_valid,
  input  wire logic         i_out_ready,
  output logic [W-1:0]      o_out_data
);
  import dtc_pkg::*;

  logic [W-1:0] mem_q [2];
  logic         wp_q;
  logic         rp_q;
  logic [1:0]   cnt_q;
  wire          push = i_in_valid && o_in_ready;
  wire          pop  = o_out_valid && i_out_ready;

  // full and empty straight from the fill count
  assign o_in_ready  = (cnt_q != 2'h2);
  assign o_out_valid = (cnt_q != 2'h0);
  assign o_out_data  = mem_q[rp_q];

  // pointers and count
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      wp_q  <= 1'b0;
      rp_q  <= 1'b0;
      cnt_q <= 2'h0;
    end else begin
      if (push) wp_q <= ~wp_q;
      if (pop) rp_q <= ~rp_q;
      if (push && !pop) cnt_q <= cnt_q + 2'h1;
      else if (pop && !push) cnt_q <= cnt_q - 2'h1;
    end
  end

  // storage; no reset needed, valid guards the content
  always_ff @(posedge i_core_clk) begin
    if (push) mem_q[wp_q] <= i_in_data;
  end
endmodule

/* File: dtc_top.sv */
/*
  Dma transfer control: three channels moving one byte per trigger from a
  source to a destination address on the system bus, with a register port
  for software and a sticky record of peripheral flag events.
  Assumes flags, the cpu read-modify-write indication and the bus wait come
  from logic on i_core_clk, so they are read without synchronisers.
*/
// Our own choices: the plain strobed port and the placing of the registers.
`timescale 1ns/1ns
`include "dtc_defs.svh"

module dtc_top (
  input  wire logic                  i_core_clk,
  input  wire logic                  i_resetn,
  input  wire logic [7:0]            i_reg_addr,
  input  wire logic [31:0]           i_reg_wdata,
  input  wire logic                  i_reg_wr,
  input  wire logic                  i_reg_word,
  input  wire logic                  i_reg_rd,
  output logic [31:0]                o_reg_rdata,
  input  wire logic [`DTC_NFLAG-1:0] i_periph_flags,
  input  wire logic                  i_cpu_rmw,
  output dtc_pkg::dtc_addr_t         o_bus_addr,
  output logic                       o_bus_rd,
  output logic                       o_bus_wr,
  output logic [7:0]                 o_bus_wdata,
  input  wire logic [7:0]            i_bus_rdata,
  input  wire logic                  i_bus_wait
);
  import dtc_pkg::*;

  // first pending channel in index order, lowest wins
  function automatic dtc_ch_t pick_first(input logic [`DTC_NCH-1:0] v);
    dtc_ch_t r;
    r = 2'h0;
    for (int i = `DTC_NCH - 1; i >= 0; i--) begin
      if (v[i]) r = 2'(i);
    end
    return r;
  endfunction

  // address load value: a word access only carries the low 16 bits
  function automatic dtc_addr_t load_addr(input logic [31:0] d, input logic word);
    return word ? (d[`DTC_AW-1:0] & `DTC_WORD_MASK) : d[`DTC_AW-1:0];
  endfunction

  // channel register hit: upper nibble is channel plus one
  function automatic logic ch_hit(input logic [7:0] a, input int ch, input logic [3:0] off);
    return (a[7:4] == 4'(ch + 1)) && (a[3:0] == off);
  endfunction

  dtc_state_t                state_q;
  dtc_ch_t                   act_q;
  logic                      defer_q;
  logic [`DTC_NCH-1:0]       pend_q;
  logic [`DTC_NFLAG-1:0]     flag_q;
  logic [`DTC_NFLAG-1:0]     flag_prev_q;
  logic [31:0]               rdata_q;
  dtc_addr_t                 addr_q;
  logic                      rd_q;
  logic                      wr_q;
  logic [7:0]                wdata_q;
  logic [`DTC_CHCTL_W-1:0]   ctl_w [`DTC_NCH];
  dtc_addr_t                 sa_w  [`DTC_NCH];
  dtc_addr_t                 da_w  [`DTC_NCH];
  logic [`DTC_NCH-1:0]       en_vec;
  logic [`DTC_NCH-1:0]       trig_hit;
  logic [31:0]               rdata_d;

  // flag edges; a rising flag is one trigger
  wire [`DTC_NFLAG-1:0] flag_rise = i_periph_flags & ~flag_prev_q;

  // register write decode
  wire wr_ctrl = i_reg_wr && (i_reg_addr == `DTC_RA_CTRL);
  wire wr_stat = i_reg_wr && (i_reg_addr == `DTC_RA_STAT);

  // buffer handshake
  wire        buf_in_ready;
  wire        buf_out_valid;
  wire [27:0] buf_out_data;

  // arbitration
  wire [`DTC_NCH-1:0] elig  = pend_q & en_vec;
  wire dtc_ch_t       grant = pick_first(elig);
  wire rmw_block = defer_q && i_cpu_rmw;
  // a register write cycle never overlaps a transfer start, so a channel
  // never latches a half-updated address
  wire start = (state_q == DTC_IDLE) && (|elig) && !rmw_block
               && !i_reg_wr && buf_in_ready;
  wire push  = (state_q == DTC_RD) && !i_bus_wait;
  wire done  = (state_q == DTC_WR) && wr_q && !i_bus_wait;
  wire [`DTC_NCH-1:0] done_mask = done ? (`DTC_NCH'(1) << act_q) : '0;

  // per-channel control and address registers
  for (genvar c = 0; c < `DTC_NCH; c++) begin : g_ch
    logic [`DTC_CHCTL_W-1:0] ctl_q;
    dtc_addr_t               sa_q;
    dtc_addr_t               da_q;
    wire wr_ctl = i_reg_wr && ch_hit(i_reg_addr, c, `DTC_RO_CTL);
    wire wr_sa  = i_reg_wr && ch_hit(i_reg_addr, c, `DTC_RO_SA);
    wire wr_da  = i_reg_wr && ch_hit(i_reg_addr, c, `DTC_RO_DA);
    wire bump   = done && (act_q == 2'(c));

    assign ctl_w[c]  = ctl_q;
    assign sa_w[c]   = sa_q;
    assign da_w[c]   = da_q;
    assign en_vec[c] = ctl_q[`DTC_CHCTL_EN];
    // each channel compares its own select, so one flag may feed several
    assign trig_hit[c] = flag_rise[ctl_q[`DTC_CHCTL_SEL +: 2]];

    // a cpu write beats the post-transfer increment
    always_ff @(posedge i_core_clk or negedge i_resetn) begin
      if (!i_resetn) begin
        ctl_q <= `DTC_CHCTL_RST;
        sa_q  <= `DTC_ADDR_RST;
        da_q  <= `DTC_ADDR_RST;
      end else begin
        if (wr_ctl) ctl_q <= i_reg_wdata[`DTC_CHCTL_W-1:0];
        if (wr_sa) sa_q <= load_addr(i_reg_wdata, i_reg_word);
        else if (bump && ctl_q[`DTC_CHCTL_SINC]) sa_q <= sa_q + 20'h1;
        if (wr_da) da_q <= load_addr(i_reg_wdata, i_reg_word);
        else if (bump && ctl_q[`DTC_CHCTL_DINC]) da_q <= da_q + 20'h1;
      end
    end
  end

  // pending requests and flag record; a new event wins over a clear
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      pend_q      <= '0;
      flag_q      <= '0;
      flag_prev_q <= '0;
      defer_q     <= 1'b0;
    end else begin
      pend_q      <= (pend_q & ~done_mask) | trig_hit;
      // only software write-one clears; transfers never touch it
      flag_q      <= (flag_q & ~(wr_stat ? i_reg_wdata[`DTC_NFLAG-1:0] : '0))
                     | flag_rise;
      flag_prev_q <= i_periph_flags;
      if (wr_ctrl) defer_q <= i_reg_wdata[`DTC_CTRL_DEFER];
    end
  end

  // transfer engine: read one byte, park it, write it out
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      state_q <= DTC_IDLE;
      act_q   <= 2'h0;
      addr_q  <= `DTC_ADDR_RST;
      rd_q    <= 1'b0;
      wr_q    <= 1'b0;
      wdata_q <= 8'h00;
    end else begin
      case (state_q)
        DTC_IDLE: begin
          if (start) begin
            act_q   <= grant;
            addr_q  <= sa_w[grant];
            rd_q    <= 1'b1;
            state_q <= DTC_RD;
          end
        end
        DTC_RD: begin
          // access stays up while the target inserts wait states
          if (!i_bus_wait) begin
            rd_q    <= 1'b0;
            state_q <= DTC_WR;
          end
        end
        DTC_WR: begin
          if (!wr_q && buf_out_valid) begin
            wr_q    <= 1'b1;
            addr_q  <= buf_out_data[27:8];
            wdata_q <= buf_out_data[7:0];
          end else if (wr_q && !i_bus_wait) begin
            wr_q    <= 1'b0;
            state_q <= DTC_IDLE;
          end
        end
        default: state_q <= DTC_IDLE;
      endcase
    end
  end

  // holds {destination, byte} between the read and the write beat
  dtc_buf #(
    .W (`DTC_BUF_W)
  ) u_buf (
    .i_core_clk  (i_core_clk),
    .i_resetn    (i_resetn),
    .i_in_valid  (push),
    .o_in_ready  (buf_in_ready),
    .i_in_data   ({da_w[act_q], i_bus_rdata}),
    .o_out_valid (buf_out_valid),
    .i_out_ready (done),
    .o_out_data  (buf_out_data)
  );

  // read decode; unmapped offsets answer zero
  always_comb begin
    rdata_d = 32'h0000_0000;
    if (i_reg_addr == `DTC_RA_CTRL) begin
      rdata_d[`DTC_CTRL_DEFER] = defer_q;
    end else if (i_reg_addr == `DTC_RA_STAT) begin
      rdata_d[`DTC_NFLAG-1:0]      = flag_q;
      rdata_d[`DTC_STAT_BUSY]      = (state_q != DTC_IDLE);
      rdata_d[`DTC_STAT_CH +: 2]   = act_q;
    end else begin
      for (int c = 0; c < `DTC_NCH; c++) begin
        if (ch_hit(i_reg_addr, c, `DTC_RO_CTL)) rdata_d[`DTC_CHCTL_W-1:0] = ctl_w[c];
        if (ch_hit(i_reg_addr, c, `DTC_RO_SA)) rdata_d[`DTC_AW-1:0] = sa_w[c];
        if (ch_hit(i_reg_addr, c, `DTC_RO_DA)) rdata_d[`DTC_AW-1:0] = da_w[c];
      end
    end
  end

  // read data stands in the cycle after the strobe only
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) rdata_q <= 32'h0000_0000;
    else rdata_q <= i_reg_rd ? rdata_d : 32'h0000_0000;
  end

  // every output straight from a flip-flop, so the far side sees no glitches
  assign o_reg_rdata = rdata_q;
  assign o_bus_addr  = addr_q;
  assign o_bus_rd    = rd_q;
  assign o_bus_wr    = wr_q;
  assign o_bus_wdata = wdata_q;

  // checks
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_resetn);

  property p_prio;
    start && elig[0] |=> (act_q == 2'h0) && o_bus_rd;
  endproperty
  a_prio: assert property (p_prio) else $error("channel 0 lost arbitration");

  property p_shared_trig;
    (ctl_w[0][5:4] == ctl_w[2][5:4]) && flag_rise[ctl_w[0][5:4]] |=> pend_q[0] && pend_q[2];
  endproperty
  a_shared_trig: assert property (p_shared_trig) else $error("shared trigger missed");

  property p_defer;
    defer_q && i_cpu_rmw && (state_q == DTC_IDLE) |=> !o_bus_rd;
  endproperty
  a_defer: assert property (p_defer) else $error("transfer during cpu rmw");

  property p_enable;
    $rose(o_bus_rd) |-> en_vec[act_q];
  endproperty
  a_enable: assert property (p_enable) else $error("disabled channel started");

  property p_load20;
    i_reg_wr && !i_reg_word && ch_hit(i_reg_addr, 0, `DTC_RO_SA)
      |=> sa_w[0] == $past(i_reg_wdata[19:0]);
  endproperty
  a_load20: assert property (p_load20) else $error("20-bit address load wrong");

  property p_load16;
    i_reg_wr && i_reg_word && ch_hit(i_reg_addr, 1, `DTC_RO_DA)
      |=> da_w[1] == {4'h0, $past(i_reg_wdata[15:0])};
  endproperty
  a_load16: assert property (p_load16) else $error("word address load wrong");

  property p_keep_flags;
    !wr_stat |=> (flag_q & $past(flag_q)) == $past(flag_q);
  endproperty
  a_keep_flags: assert property (p_keep_flags) else $error("set flag dropped");

  // one read beat then one write beat; each may sit through up to 7 wait states
  property p_one_byte;
    $rose(o_bus_rd) |-> !o_bus_wr ##[1:8] ($fell(o_bus_rd) && !o_bus_wr)
      ##1 ($rose(o_bus_wr) && !o_bus_rd) ##[1:8] ($fell(o_bus_wr) && !o_bus_rd);
  endproperty
  a_one_byte: assert property (p_one_byte) else $error("transfer not one byte");

  property p_atomic;
    i_reg_wr |=> !$rose(o_bus_rd);
  endproperty
  a_atomic: assert property (p_atomic) else $error("transfer started on write");

  property p_record;
    flag_rise[`DTC_FLAG_SER0_RX] |=> flag_q[`DTC_FLAG_SER0_RX];
  endproperty
  a_record: assert property (p_record) else $error("flag event lost");

  // a stalled target must see the same beat until it lets go
  property p_rd_hold;
    o_bus_rd && i_bus_wait |=> o_bus_rd && $stable(o_bus_addr);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read beat dropped in wait");

  property p_wr_hold;
    o_bus_wr && i_bus_wait
      |=> o_bus_wr && $stable(o_bus_addr) && $stable(o_bus_wdata);
  endproperty
  a_wr_hold: assert property (p_wr_hold) else $error("write beat dropped in wait");

  property p_src_addr;
    $rose(o_bus_rd) |-> o_bus_addr == sa_w[act_q];
  endproperty
  a_src_addr: assert property (p_src_addr) else $error("read not at source address");

  property p_off_idle;
    (state_q == DTC_IDLE) && !en_vec[1] |=> !(o_bus_rd && (act_q == 2'h1));
  endproperty
  a_off_idle: assert property (p_off_idle) else $error("disabled channel 1 ran");

  property p_pend_keep;
    pend_q[1] && !en_vec[1] && !done_mask[1] |=> pend_q[1];
  endproperty
  a_pend_keep: assert property (p_pend_keep) else $error("held request lost");

  property p_record_all;
    (|flag_rise) |=> (flag_q & $past(flag_rise)) == $past(flag_rise);
  endproperty
  a_record_all: assert property (p_record_all) else $error("flag edge not recorded");

  // read data must not linger past its one cycle
  property p_rdata_idle;
    !i_reg_rd |=> o_reg_rdata == 32'h0000_0000;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data lingers");

  // main scenarios: contention, wait states, deferral, shared flag, held-off channel
  c_two_pending: cover property (elig[0] && elig[2] && start);
  c_wait_write:  cover property (o_bus_wr && i_bus_wait ##1 o_bus_wr && !i_bus_wait ##1 !o_bus_wr);
  c_deferred:    cover property (rmw_block && |elig ##1 !rmw_block ##1 o_bus_rd);
  c_shared_flag: cover property (trig_hit[0] && trig_hit[2]);
  c_held_off:    cover property (pend_q[1] && !en_vec[1] ##1 pend_q[1] && en_vec[1]);
endmodule

/* File: dtc_bus_model.sv */
/*
  Behavioural system-bus target for the dma block: reads return a[7:0] xor 5a, writes are not stored, plus wait states.
  Assumes it shares i_core_clk with the block and is the only bus target.
*/
`timescale 1ns/1ns

module dtc_bus_model (
  input  wire logic        i_core_clk,
  input  wire logic        i_resetn,
  input  wire logic [19:0] i_bus_addr,
  input  wire logic        i_bus_rd,
  input  wire logic        i_bus_wr,
  input  wire logic [2:0]  i_wait_n,
  output logic [7:0]       o_bus_rdata,
  output logic             o_bus_wait
);
  logic [2:0] cnt_q;
  logic [7:0] last_q;
  logic       acc;

  // every access is stalled i_wait_n cycles, like a busy multiplier unit
  assign acc         = i_bus_rd | i_bus_wr;
  assign o_bus_wait  = acc && (cnt_q < i_wait_n);
  // data only in the taking cycle; otherwise a pattern that keeps changing
  assign o_bus_rdata = (i_bus_rd && !o_bus_wait) ? (i_bus_addr[7:0] ^ 8'h5a) : ~last_q;

  // wait counter restarts once an access is taken
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      cnt_q  <= 3'h0;
      last_q <= 8'h00;
    end else begin
      cnt_q  <= (acc && o_bus_wait) ? cnt_q + 3'h1 : 3'h0;
      last_q <= o_bus_rdata;
    end
  end
endmodule

/* File: tb.sv */
/*
  Self-checking bench for dtc_top: register port, flag triggers and bus transfers.
  Assumes dtc_bus_model answers a read of address a with a[7:0] xor 5a.
*/
`timescale 1ns/1ns
`include "dtc_defs.svh"

module tb;
  logic               i_core_clk, i_resetn, i_reg_wr, i_reg_word, i_reg_rd, i_cpu_rmw;
  logic [7:0]         i_reg_addr, i_bus_rdata, o_bus_wdata;
  logic [31:0]        i_reg_wdata, o_reg_rdata;
  logic [3:0]         i_periph_flags, rec;
  logic [2:0]         wait_n;
  logic               o_bus_rd, o_bus_wr, i_bus_wait, rd_seen;
  dtc_pkg::dtc_addr_t o_bus_addr;
  logic [19:0]        sa [3];
  logic [19:0]        da [3];
  logic [5:0]         ctl [3];
  logic [31:0]        rq [$];
  logic [31:0]        mq [$];
  logic [31:0]        wq [$];
  int                 n_fail, checked, cyc;

  dtc_top dut (.i_core_clk(i_core_clk), .i_resetn(i_resetn), .i_reg_addr(i_reg_addr),
    .i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr), .i_reg_word(i_reg_word),
    .i_reg_rd(i_reg_rd), .o_reg_rdata(o_reg_rdata), .i_periph_flags(i_periph_flags),
    .i_cpu_rmw(i_cpu_rmw), .o_bus_addr(o_bus_addr), .o_bus_rd(o_bus_rd),
    .o_bus_wr(o_bus_wr), .o_bus_wdata(o_bus_wdata), .i_bus_rdata(i_bus_rdata),
    .i_bus_wait(i_bus_wait));
  dtc_bus_model peer (.i_core_clk(i_core_clk), .i_resetn(i_resetn), .i_bus_addr(o_bus_addr),
    .i_bus_rd(o_bus_rd), .i_bus_wr(o_bus_wr), .i_wait_n(wait_n),
    .o_bus_rdata(i_bus_rdata), .o_bus_wait(i_bus_wait));

  always #2 i_core_clk = ~i_core_clk;

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // strobes last one cycle and are followed by a quiet cycle
  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d, input logic w);
    i_reg_addr  <= a;
    i_reg_wdata <= d;
    i_reg_word  <= w;
    i_reg_wr    <= 1'b1;
    @(posedge i_core_clk);
    i_reg_wr <= 1'b0;
    @(posedge i_core_clk);
  endtask

  task automatic reg_rd(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m);
    rq.push_back(exp);
    mq.push_back(m);
    i_reg_addr <= a;
    i_reg_rd   <= 1'b1;
    @(posedge i_core_clk);
    i_reg_rd <= 1'b0;
    @(posedge i_core_clk);
  endtask

  task automatic cfg(input int c, input logic [19:0] s, input logic [19:0] d,
                     input logic [5:0] ct);
    logic [7:0] b;
    b = 8'(16 * (c + 1));
    sa[c]  = s;
    da[c]  = d;
    ctl[c] = ct;
    reg_wr(b + {4'h0, `DTC_RO_SA}, {12'h0, s}, 1'b0);
    reg_wr(b + {4'h0, `DTC_RO_DA}, {12'h0, d}, 1'b0);
    reg_wr(b, {26'h0, ct}, 1'b0);
  endtask

  // expected destination write, then the address steps the channel should take
  task automatic xfer(input int c);
    wq.push_back({4'h0, da[c], sa[c][7:0] ^ 8'h5a});
    if (ctl[c][`DTC_CHCTL_SINC]) sa[c] = sa[c] + 20'h1;
    if (ctl[c][`DTC_CHCTL_DINC]) da[c] = da[c] + 20'h1;
  endtask

  task automatic pulse(input logic [3:0] m);
    rec = rec | m;
    wait_n <= 3'($urandom_range(3, 0));
    i_periph_flags <= m;
    @(posedge i_core_clk);
    i_periph_flags <= 4'h0;
    @(posedge i_core_clk);
  endtask

  task automatic drain();
    for (int i = 0; i < 150 && wq.size() != 0; i++) @(posedge i_core_clk);
    chk(32'(wq.size()), 32'h0);
    repeat (3) @(posedge i_core_clk);
  endtask

  // watcher: register read data one cycle after the strobe, bus writes as taken
  always @(posedge i_core_clk) begin
    cyc++;
    if (rd_seen) chk(o_reg_rdata & mq.pop_front(), rq.pop_front());
    if (o_bus_wr && !i_bus_wait) begin
      if (wq.size() == 0) chk(32'h1, 32'h0);
      else chk({4'h0, o_bus_addr, o_bus_wdata}, wq.pop_front());
    end
    rd_seen = i_reg_rd;
    if (cyc == 20000) begin
      n_fail++;
      wrap_up();
    end
  end

  initial begin
    {i_core_clk, i_resetn, i_reg_wr, i_reg_word, i_reg_rd, i_cpu_rmw, rd_seen} = 7'h0;
    i_reg_addr = 8'h00;
    i_reg_wdata = 32'h0;
    i_periph_flags = 4'h0;
    wait_n = 3'h0;
    rec = 4'h0;
    void'($urandom(55));
    repeat (2) @(posedge i_core_clk);
    i_resetn <= 1'b1;
    @(posedge i_core_clk);
    // reset values, including unmapped holes, all read as zero
    for (int i = 0; i < 17; i++) reg_rd(8'(4 * i), 32'h0, 32'hffffffff);
    // full and word-sized address loads on every channel
    for (int c = 0; c < 3; c++) begin
      sa[c] = 20'($urandom());
      reg_wr(8'(16 * c + 20), {12'hfff, sa[c]}, 1'b0);
      reg_rd(8'(16 * c + 20), {12'h0, sa[c]}, 32'hffffffff);
      reg_wr(8'(16 * c + 24), {12'hfff, sa[c]}, 1'b1);
      reg_rd(8'(16 * c + 24), {16'h0, sa[c][15:0]}, 32'hffffffff);
    end
    // ch0 and ch2 share the serial rx flag, ch1 uses tx; lowest channel first
    cfg(0, 20'($urandom()), 20'($urandom()), 6'h17);
    cfg(1, 20'($urandom()), 20'($urandom()), 6'h01);
    cfg(2, 20'($urandom()), 20'($urandom()), 6'h11);
    for (int k = 0; k < 2; k++) begin
      pulse(4'h2);
      xfer(0);
      xfer(2);
      drain();
    end
    pulse(4'h3);
    for (int c = 0; c < 3; c++) xfer(c);
    drain();
    // a disabled channel keeps its request and serves it only once enabled
    ctl[1] = 6'h00;
    reg_wr(8'h10 * 2, 32'h0, 1'b0);
    pulse(4'h1);
    repeat (12) @(posedge i_core_clk);
    // enable, then a back-to-back source load: the start must wait for the load
    ctl[1] = 6'h01;
    sa[1] = 20'($urandom());
    i_reg_addr  <= 8'h20;
    i_reg_wdata <= 32'h1;
    i_reg_word  <= 1'b0;
    i_reg_wr    <= 1'b1;
    @(posedge i_core_clk);
    i_reg_addr  <= 8'h24;
    i_reg_wdata <= {12'h0, sa[1]};
    @(posedge i_core_clk);
    i_reg_wr <= 1'b0;
    xfer(1);
    drain();
    // deferral holds starts off while a cpu read-modify-write runs
    reg_wr(`DTC_RA_STAT, 32'hf, 1'b0);
    rec = 4'h0;
    reg_wr(`DTC_RA_CTRL, 32'h1, 1'b0);
    i_cpu_rmw <= 1'b1;
    pulse(4'h2);
    repeat (8) begin
      chk({31'h0, o_bus_rd}, 32'h0);
      @(posedge i_core_clk);
    end
    reg_wr(`DTC_RA_CTRL, 32'h0, 1'b0);
    pulse(4'h8);
    i_cpu_rmw <= 1'b0;
    xfer(0);
    xfer(2);
    drain();
    reg_rd(`DTC_RA_STAT, {28'h0, rec}, 32'h10f);
    reg_wr(`DTC_RA_STAT, 32'h2, 1'b0);
    reg_rd(`DTC_RA_STAT, 32'h8, 32'h10f);
    // let the watcher take the last read before the verdict
    repeat (2) @(posedge i_core_clk);
    wrap_up();
  end
endmodule
